// ### bench/lane_sets_model.sv
`timescale 1ns/1ns
`default_nettype none
module lane_sets_model
    import shared_bank_pkg::*;
(
    // Clock
    input  wire logic                  mclk,
    // Lane side of the bank
    input  wire lane_wr_t              lane_wr,
    input  wire logic [SEL_LANE_W-1:0] lane_rd_sel,
    input  wire logic [7:0]            lane_rd_addr,
    input  wire logic                  lane_rd,
    output logic [7:0]                 lane_rdata
);
    // ------------------------------------------------------------
    // Four lane register sets
    // ------------------------------------------------------------
    logic [7:0] mem [NUM_LANES][256];
    logic [7:0] junk;

    initial
    begin
        junk = 8'h3C;
        foreach (mem[l, a])
            mem[l][a] = 8'h00;
    end

    always @(posedge mclk)
    begin
        junk <= ~junk; // Idle bus toggles so a stale value never matches
        for (int l = 0; l < NUM_LANES; l++)
            if (lane_wr.en[l])
                mem[l][lane_wr.addr] <= lane_wr.data;
    end

    assign lane_rdata = lane_rd ? mem[lane_rd_sel][lane_rd_addr] : junk;
endmodule
`default_nettype wire

// ### bench/shared_reg_bank_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module shared_reg_bank_asserts
    import shared_bank_pkg::*;
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    // Host port
    input  wire host_req_t            req,
    input  wire logic [7:0]           rdata,
    input  wire logic                 rvalid,
    // Lane side
    input  wire lane_wr_t             lane_wr,
    input  wire logic                 lane_rd,
    input  wire logic [7:0]           lane_rd_addr,
    input  wire logic [7:0]           lane_rdata,
    // Strap and pulses
    input  wire logic [STRAP_W-1:0]   addr_strap,
    input  wire logic [6:0]           bus_address,
    input  wire logic                 bus_master_reset,
    input  wire logic                 shared_regs_reset_pulse
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence rd_taken;
        ce && req.rd;
    endsequence
    sequence strap_steady;
        (ce && $stable(addr_strap)) [*3];
    endsequence

    a_read_answer: assert property (rd_taken |=> rvalid)
        else $error("read got no answer");
    a_idle_quiet: assert property (ce && !req.rd |=> !rvalid && $stable(rdata))
        else $error("read data moved without a read");
    a_ce_freeze: assert property (!ce |=> $stable(rvalid) && $stable(rdata) && $stable(lane_wr))
        else $error("state moved while clock enable low");
    a_lane_read: assert property (rd_taken ##0 lane_rd |=> rdata == $past(lane_rdata))
        else $error("lane read data lost");
    a_lane_rd_addr: assert property (lane_rd |-> req.rd && lane_rd_addr == req.addr && req.addr != ADDR_SEL)
        else $error("lane read misdirected");
    a_lane_wr_shape: assert property ((|lane_wr.en) |-> $onehot(lane_wr.en) || lane_wr.en == 4'hF)
        else $error("lane write enables malformed");
    a_lane_wr_cause: assert property ((|lane_wr.en) |-> $past(ce && req.wr && req.addr != ADDR_SEL)
        && lane_wr.addr == $past(req.addr) && lane_wr.data == $past(req.wdata))
        else $error("lane write without matching request");
    a_sel_no_lane: assert property (ce && req.wr && req.addr == ADDR_SEL |=> lane_wr.en == 4'h0)
        else $error("selector write reached a lane");
    a_shared_rst: assert property (shared_regs_reset_pulse |-> !bus_master_reset
        && $past(ce && req.wr && req.addr == ADDR_CTRL && req.wdata[CTRL_SHARED_RST_BIT]))
        else $error("shared reset pulse without cause");
    a_master_rst: assert property (bus_master_reset |-> $past(ce && req.wr && req.addr == ADDR_CTRL
        && req.wdata[CTRL_MASTER_RST_BIT] && !req.wdata[CTRL_SHARED_RST_BIT]))
        else $error("master reset pulse without cause");
    a_bus_addr: assert property (strap_steady |-> bus_address == BUS_ADDR_BASE + 7'(addr_strap))
        else $error("bus address wrong");
endmodule

bind shared_reg_bank shared_reg_bank_asserts chk_u (.mclk, .rstn, .ce, .req, .rdata, .rvalid, .lane_wr, .lane_rd,
    .lane_rd_addr, .lane_rdata, .addr_strap, .bus_address, .bus_master_reset, .shared_regs_reset_pulse);
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import shared_bank_pkg::*;
;
    localparam logic [2:0] VER = 3'h5;  // Arbitrary
    localparam logic [4:0] PID = 5'h13; // Arbitrary
    logic       mclk, rstn, ce, rvalid, lane_rd, force_config_load, config_load_disable;
    logic       bus_master_reset, shared_regs_reset_pulse, config_load_done;
    host_req_t  req;
    lane_wr_t   lane_wr;
    logic [7:0] rdata, lane_rd_addr, lane_rdata, d, b, a [4], v [4];
    logic [7:0] rw_addr [3];
    logic [15:0] rst_tab [8];
    logic [1:0] lane_rd_sel;
    logic [3:0] addr_strap, lane_irq, m;
    logic [6:0] bus_address;
    int         fails, checks;

    shared_reg_bank #(.VERSION_CODE(VER), .PART_IDENTITY(PID)) dut_u (.mclk, .rstn, .ce, .req, .rdata, .rvalid,
        .lane_wr, .lane_rd_sel, .lane_rd_addr, .lane_rd, .lane_rdata, .addr_strap, .bus_address, .force_config_load,
        .config_load_disable, .bus_master_reset, .shared_regs_reset_pulse, .config_load_done, .lane_irq);
    lane_sets_model lanes_u (.mclk, .lane_wr, .lane_rd_sel, .lane_rd_addr, .lane_rd, .lane_rdata);

    // ------------------------------------------------------------
    // Host tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] da);
        @(negedge mclk);
        req = '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: da};
        @(negedge mclk);
        req.wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
        @(negedge mclk);
        req = '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
        @(negedge mclk);
        req.rd = 1'b0;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, exp);
    endtask

    task automatic complete_run;
        $display("checks %0d, fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial
    begin
        #200000;
        fails++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        fails = 0;
        checks = 0;
        d = 8'($urandom(32'h014A));
        rstn = 1'b0;
        ce = 1'b1;
        req = '0;
        config_load_done = 1'b0;
        lane_irq = 4'h0;
        addr_strap = 4'($urandom);
        rst_tab = '{{8'h01, VER, PID}, 16'h0200, 16'h0300, 16'h0401, 16'h0510, 16'h0600, 16'h0705, 16'h4000};
        rw_addr = '{ADDR_RSV2, ADDR_RSV6, ADDR_RSV7};
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        repeat (2) @(negedge mclk);
        rd_chk(ADDR_STRAP, {addr_strap, 4'h0});
        chk({1'b0, bus_address}, {1'b0, BUS_ADDR_BASE + 7'(addr_strap)});
        foreach (rst_tab[i])
            rd_chk(rst_tab[i][15:8], rst_tab[i][7:0]);
        $display("test reset values done");

        wr(ADDR_STRAP, 8'hFF);
        wr(ADDR_IDENT, 8'h00);
        wr(ADDR_STAT, 8'h1F);
        rd_chk(ADDR_STRAP, {addr_strap, 4'h0});
        rd_chk(ADDR_IDENT, {VER, PID});
        rd_chk(ADDR_STAT, 8'h10);
        foreach (rw_addr[i])
        begin
            d = 8'($urandom);
            wr(rw_addr[i], d);
            rd_chk(rw_addr[i], d);
        end
        wr(ADDR_STAT, 8'hE0);
        chk({7'h00, config_load_disable}, 8'h01);
        rd_chk(ADDR_STAT, 8'hF0);
        wr(ADDR_CTRL, 8'h61);
        chk({6'h00, shared_regs_reset_pulse, bus_master_reset}, 8'h02);
        foreach (rst_tab[i])
            rd_chk(rst_tab[i][15:8], rst_tab[i][7:0]);
        $display("test read-only and shared reset done");

        wr(ADDR_CTRL, 8'h21);
        chk({7'h00, bus_master_reset}, 8'h01);
        rd_chk(ADDR_CTRL, 8'h01);
        wr(ADDR_CTRL, 8'h11);
        chk({7'h00, force_config_load}, 8'h01);
        rd_chk(ADDR_STAT, 8'h00);
        @(negedge mclk);
        config_load_done = 1'b1;
        @(negedge mclk);
        config_load_done = 1'b0;
        rd_chk(ADDR_STAT, 8'h10);
        wr(ADDR_CTRL, 8'h01);
        repeat (4)
        begin
            m = 4'($urandom);
            @(negedge mclk);
            lane_irq = m;
            @(negedge mclk);
            lane_irq = 4'h0;
            rd_chk(ADDR_STAT, {4'h1, m[0], m[1], m[2], m[3]});
            rd_chk(ADDR_STAT, 8'h10);
        end
        $display("test load control and flags done");

        for (int l = 0; l < 4; l++)
        begin
            a[l] = {1'b0, 7'($urandom)};
            v[l] = 8'($urandom);
            wr(ADDR_SEL, {4'h0, 2'b01, 2'(l)});
            chk({4'h0, lane_wr.en}, 8'h00);
            wr(a[l], v[l]);
            chk({4'h0, lane_wr.en}, 8'h01 << l);
        end
        for (int l = 0; l < 4; l++)
        begin
            wr(ADDR_SEL, {4'h0, 2'b01, 2'(l)});
            rd_chk(a[l], v[l]);
        end
        d = 8'($urandom);
        b = {1'b1, 6'($urandom), 1'b0};
        wr(ADDR_SEL, 8'h0E);
        wr(b, d);
        chk({4'h0, lane_wr.en}, 8'h0F);
        wr(a[0], ~d);
        chk({4'h0, lane_wr.en}, 8'h0F);
        rd_chk(b, d);
        for (int l = 0; l < 4; l++)
        begin
            wr(ADDR_SEL, {4'h0, 2'b11, 2'(l)});
            rd_chk(a[0], ~d);
        end
        wr(ADDR_SEL, 8'h05);
        wr(b, ~d);
        chk({4'h0, lane_wr.en}, 8'h02);
        rd_chk(b, ~d);
        wr(ADDR_SEL, 8'h06);
        rd_chk(b, d);
        wr(ADDR_SEL, 8'h00);
        rd_chk(ADDR_RSV7, 8'h05);
        $display("test lane steering done");
        ce = 1'b0;
        lane_irq = 4'hF;
        wr(ADDR_RSV2, 8'hA5);
        ce = 1'b1;
        lane_irq = 4'h0;
        rd_chk(ADDR_RSV2, RST_RSV2);
        rd_chk(ADDR_STAT, 8'h10);
        $display("test clock enable freeze done");
        complete_run();
    end
endmodule
`default_nettype wire

// ### hw/irq_sticky.sv
`timescale 1ns/1ns
`default_nettype none
module irq_sticky
    import shared_bank_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic ce,
    // Event and clear
    input  wire logic set_evt,
    input  wire logic clr,
    output logic      flag
);

    typedef struct packed {
        logic flag;
    } sticky_state_t;

    sticky_state_t cur;
    sticky_state_t next_cur;

    // Set wins over clear so no event is lost
    always_comb
    begin
        next_cur = cur;
        if (set_evt)
        begin
            next_cur.flag = 1'b1;
        end
        else if (clr)
        begin
            next_cur.flag = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            cur <= '0;
        end
        else if (ce)
        begin
            cur <= next_cur;
        end
    end

    assign flag = cur.flag;

endmodule
`default_nettype wire

// ### hw/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync
    import shared_bank_pkg::*;
#(
    parameter int W = 4
)(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic         ce,
    // Pins in, synchronised out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t cur;
    sync_state_t next_cur;

    // Only the second stage is visible to the block
    always_comb
    begin
        next_cur        = cur;
        next_cur.meta   = pin_in;
        next_cur.stable = cur.meta;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            cur <= '0;
        end
        else if (ce)
        begin
            cur <= next_cur;
        end
    end

    assign pin_out = cur.stable;

endmodule
`default_nettype wire

// ### hw/shared_reg_bank.sv
`timescale 1ns/1ns
`default_nettype none
module shared_reg_bank
    import shared_bank_pkg::*;
#(
    parameter logic [2:0] VERSION_CODE  = 3'h2,  // Arbitrary value
    parameter logic [4:0] PART_IDENTITY = 5'h0A  // Arbitrary value
)(
    // Clock, reset, enable
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    // Host register port
    input  wire host_req_t            req,
    output logic [7:0]                rdata,
    output logic                      rvalid,
    // Lane register sets
    output lane_wr_t                  lane_wr,
    output logic [SEL_LANE_W-1:0]     lane_rd_sel,
    output logic [7:0]                lane_rd_addr,
    output logic                      lane_rd,
    input  wire logic [7:0]           lane_rdata,
    // Strap pins and bus address
    input  wire logic [STRAP_W-1:0]   addr_strap,
    output logic [6:0]                bus_address,
    // EEPROM load control
    output logic                      force_config_load,
    output logic                      config_load_disable,
    output logic                      bus_master_reset,
    output logic                      shared_regs_reset_pulse,
    input  wire logic                 config_load_done,
    // Lane interrupts
    input  wire logic [NUM_LANES-1:0] lane_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] rsv2;
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic [7:0] rsv6;
        logic [7:0] rsv7;
        logic       done;
        logic [7:0] rdata;
        logic       rvalid;
        lane_wr_t   lane_wr;
        logic       master_rst;
        logic       shared_rst;
    } bank_state_t;

    bank_state_t cur;
    bank_state_t next_cur;

    logic [STRAP_W-1:0]   strap_sync;
    logic [NUM_LANES-1:0] irq_flag;
    logic                 stat_read;
    logic                 lane_mode;
    logic                 bcast;
    logic                 is_shared_rst;
    logic [7:0]           shared_rd;
    logic [7:0]           irq_byte;

    // ------------------------------------------------------------
    // Strap pins and interrupt flags
    // ------------------------------------------------------------
    pin_sync #(
        .W (STRAP_W)
    ) u_strap_sync (
        .mclk    (mclk),
        .rstn    (rstn),
        .ce      (ce),
        .pin_in  (addr_strap),
        .pin_out (strap_sync)
    );

    // Flags clear when status is read; a new event in that cycle wins
    assign stat_read = req.rd && !lane_mode && (req.addr == ADDR_STAT);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LANES; gi++)
        begin : g_irq
            irq_sticky u_flag (
                .mclk    (mclk),
                .rstn    (rstn),
                .ce      (ce),
                .set_evt (lane_irq[gi]),
                .clr     (stat_read),
                .flag    (irq_flag[gi])
            );
        end
    endgenerate

    // Lane 0 sits in the highest flag bit
    always_comb
    begin
        irq_byte = ZERO_BYTE;
        for (int i = 0; i < NUM_LANES; i++)
        begin
            irq_byte[NUM_LANES-1-i] = irq_flag[i];
        end
    end

    // ------------------------------------------------------------
    // Steering
    // ------------------------------------------------------------
    assign lane_mode = cur.sel[SEL_EN_BIT];
    assign bcast     = cur.sel[SEL_BCAST_BIT] && lane_mode;

    assign is_shared_rst = req.wr && !lane_mode && (req.addr == ADDR_CTRL)
                           && req.wdata[CTRL_SHARED_RST_BIT];

    // Lane reads go out combinationally; the answer is caught next edge
    assign lane_rd      = req.rd && lane_mode && (req.addr != ADDR_SEL);
    assign lane_rd_addr = req.addr;
    assign lane_rd_sel  = cur.sel[SEL_LANE_LSB +: SEL_LANE_W];

    // ------------------------------------------------------------
    // Shared read mux
    // ------------------------------------------------------------
    always_comb
    begin
        shared_rd = ZERO_BYTE;
        case (req.addr)
            ADDR_STRAP:
            begin
                shared_rd[STRAP_LSB +: STRAP_W] = strap_sync;
            end
            ADDR_IDENT:
            begin
                shared_rd = {VERSION_CODE, PART_IDENTITY};
            end
            ADDR_RSV2:
            begin
                shared_rd = cur.rsv2;
            end
            ADDR_CTRL:
            begin
                shared_rd = cur.ctrl; // self-clearing bits are never stored
            end
            ADDR_STAT:
            begin
                shared_rd = cur.stat | irq_byte;
                shared_rd[STAT_DONE_BIT] = cur.done;
            end
            ADDR_RSV6:
            begin
                shared_rd = cur.rsv6;
            end
            ADDR_RSV7:
            begin
                shared_rd = cur.rsv7;
            end
            // Selector readback is not supported, so it answers zero
            default:
            begin
                shared_rd = ZERO_BYTE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_cur            = cur;
        next_cur.rvalid     = req.rd;
        next_cur.lane_wr.en = '0;
        next_cur.master_rst = 1'b0;
        next_cur.shared_rst = 1'b0;

        if (req.rd)
        begin
            // Selector address is never a lane register
            if (lane_mode && (req.addr != ADDR_SEL))
            begin
                next_cur.rdata = lane_rdata;
            end
            else
            begin
                next_cur.rdata = shared_rd;
            end
        end

        // EEPROM loader finishing sets done; set wins over clear
        if (config_load_done)
        begin
            next_cur.done = 1'b1;
        end

        if (req.wr)
        begin
            if (req.addr == ADDR_SEL)
            begin
                next_cur.sel = req.wdata;
            end
            else if (lane_mode)
            begin
                next_cur.lane_wr.addr = req.addr;
                next_cur.lane_wr.data = req.wdata;
                if (bcast)
                begin
                    next_cur.lane_wr.en = '1;
                end
                else
                begin
                    next_cur.lane_wr.en[cur.sel[SEL_LANE_LSB +: SEL_LANE_W]] = 1'b1;
                end
            end
            else
            begin
                // Strap, identity and reserved 0x03 fall through untouched
                case (req.addr)
                    ADDR_RSV2:
                    begin
                        next_cur.rsv2 = req.wdata;
                    end
                    ADDR_CTRL:
                    begin
                        next_cur.ctrl       = req.wdata & CTRL_KEEP_MASK;
                        next_cur.master_rst = req.wdata[CTRL_MASTER_RST_BIT];
                        if (req.wdata[CTRL_FORCE_LOAD_BIT] && !cur.ctrl[CTRL_FORCE_LOAD_BIT]
                            && !config_load_done)
                        begin
                            next_cur.done = 1'b0;
                        end
                    end
                    ADDR_STAT:
                    begin
                        next_cur.stat = req.wdata & STAT_RW_MASK;
                    end
                    ADDR_RSV6:
                    begin
                        next_cur.rsv6 = req.wdata;
                    end
                    ADDR_RSV7:
                    begin
                        next_cur.rsv7 = req.wdata;
                    end
                    default:
                    begin
                        next_cur.rsv2 = cur.rsv2;
                    end
                endcase
            end
        end

        // Shared reset overrides the rest of that write, except a force-load rising edge still clears done
        if (is_shared_rst)
        begin
            next_cur.sel        = RST_SEL;
            next_cur.rsv2       = RST_RSV2;
            next_cur.ctrl       = RST_CTRL;
            next_cur.stat       = RST_STAT;
            next_cur.rsv6       = RST_RSV6;
            next_cur.rsv7       = RST_RSV7;
            next_cur.master_rst = 1'b0;
            next_cur.shared_rst = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            cur         <= '0;
            cur.sel     <= RST_SEL;
            cur.rsv2    <= RST_RSV2;
            cur.ctrl    <= RST_CTRL;
            cur.stat    <= RST_STAT;
            cur.rsv6    <= RST_RSV6;
            cur.rsv7    <= RST_RSV7;
            cur.done    <= RST_DONE;
        end
        else if (ce)
        begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata                   = cur.rdata;
    assign rvalid                  = cur.rvalid;
    assign lane_wr                 = cur.lane_wr;
    assign bus_address             = BUS_ADDR_BASE + {3'h0, strap_sync};
    assign force_config_load       = cur.ctrl[CTRL_FORCE_LOAD_BIT];
    assign config_load_disable     = cur.stat[STAT_LOAD_DIS_BIT];
    assign bus_master_reset        = cur.master_rst;
    assign shared_regs_reset_pulse = cur.shared_rst;

endmodule
`default_nettype wire

// ### pkg/shared_bank_pkg.sv
`default_nettype none
package shared_bank_pkg;

    // ------------------------------------------------------------
    // Shared register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STRAP = 8'h00;
    localparam logic [7:0] ADDR_IDENT = 8'h01;
    localparam logic [7:0] ADDR_RSV2  = 8'h02;
    localparam logic [7:0] ADDR_RSV3  = 8'h03;
    localparam logic [7:0] ADDR_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_STAT  = 8'h05;
    localparam logic [7:0] ADDR_RSV6  = 8'h06;
    localparam logic [7:0] ADDR_RSV7  = 8'h07;
    localparam logic [7:0] ADDR_SEL   = 8'hFF;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SEL_BCAST_BIT       = 3;
    localparam int SEL_EN_BIT          = 2;
    localparam int SEL_LANE_LSB        = 0;
    localparam int SEL_LANE_W          = 2;
    localparam int CTRL_SHARED_RST_BIT = 6;
    localparam int CTRL_MASTER_RST_BIT = 5;
    localparam int CTRL_FORCE_LOAD_BIT = 4;
    localparam int STAT_LOAD_DIS_BIT   = 7;
    localparam int STAT_DONE_BIT       = 4;
    localparam int STRAP_LSB           = 4;
    localparam int STRAP_W             = 4;
    localparam int NUM_LANES           = 4;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SEL        = 8'h00;
    localparam logic [7:0] RST_RSV2       = 8'h00;
    localparam logic [7:0] RST_CTRL       = 8'h01;
    localparam logic [7:0] RST_STAT       = 8'h00;
    localparam logic [7:0] RST_RSV6       = 8'h00;
    localparam logic [7:0] RST_RSV7       = 8'h05;
    localparam logic       RST_DONE       = 1'b1;
    localparam logic [7:0] CTRL_KEEP_MASK = 8'h9F;
    localparam logic [7:0] STAT_RW_MASK   = 8'hE0;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;
    localparam logic [6:0] BUS_ADDR_BASE  = 7'h18;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [NUM_LANES-1:0] en;
        logic [7:0]           addr;
        logic [7:0]           data;
    } lane_wr_t;

endpackage
`default_nettype wire
